/* verilog/pot_pkg.sv */
// shared constants and types for the dual potentiometer serial port
package pot_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int STORE_TIME_MS = 10;
   // longest store time, rounded down to whole reference cycles
   localparam int STORE_CYCLES_DEF = STORE_TIME_MS * (CLK_HZ / 1000);

   localparam int NUM_POTS = 2;
   localparam int NUM_STORED = 4;
   localparam int TAP_BITS = 6;
   localparam int TAPS = 64;

   // device-type code, value arbitrary
   localparam logic [3:0] DEVICE_TYPE = 4'h3;

   // identification byte and instruction byte field positions
   localparam int ID_TYPE_LSB = 4;
   localparam int ID_ZERO_LSB = 2;
   localparam int ID_ADDR_LSB = 0;
   localparam int INSTR_OP_LSB = 4;
   localparam int INSTR_SEL_LSB = 2;
   localparam int INSTR_POT_BIT = 0;

   // operation codes
   localparam logic [3:0] OP_READ_STATUS = 4'h1;
   localparam logic [3:0] OP_READ_WIPER = 4'h9;
   localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
   localparam logic [3:0] OP_READ_STORED = 4'hb;
   localparam logic [3:0] OP_WRITE_STORED = 4'hc;
   localparam logic [3:0] OP_XFR_TO_WIPER = 4'hd;
   localparam logic [3:0] OP_XFR_TO_STORED = 4'he;

   // values after reset
   localparam logic [5:0] STORED_RESET = 6'h00;
   localparam logic [2:0] SYNC_RESET = 3'h4;
   localparam logic [2:0] LINK_SYNC_RESET = 3'h0;

   typedef enum logic [2:0] {
      PH_ID,
      PH_INSTR,
      PH_WDATA,
      PH_READ,
      PH_DONE,
      PH_IGNORE
   } phase_t;
endpackage

/* verilog/cdc_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
module cdc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } sync_t;

   sync_t r;
   sync_t n;

   always_comb begin
      n.meta = d;
      n.held = r.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= {RESET_VAL, RESET_VAL};
      end else begin
         r <= n;
      end
   end

   assign q = r.held;
endmodule

/* verilog/tap_decoder.sv */
// one-hot decode of a wiper position onto its tap switches
`timescale 1ns/1ps
module tap_decoder #(
   parameter int WIDTH = 6,
   parameter int TAPS = 64
) (
   input wire logic [WIDTH-1:0] position,
   output logic [TAPS-1:0] tap_on
);
   genvar t;
   generate
      for (t = 0; t < TAPS; t++) begin : g_tap
         assign tap_on[t] = (position == WIDTH'(t));
      end
   endgenerate
endmodule

/* verilog/dual_pot_serial_host_port.sv */
// serial host port of a dual digital potentiometer: link logic and register core
`timescale 1ns/1ps

module pot_serial_link (
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic [1:0] address_select_pins,
   input wire logic armed,
   input wire logic [pot_pkg::NUM_POTS-1:0][pot_pkg::TAP_BITS-1:0] wiper_img,
   input wire logic [pot_pkg::NUM_POTS-1:0][pot_pkg::NUM_STORED-1:0][pot_pkg::TAP_BITS-1:0]
      stored_img,
   input wire logic busy_img,
   output logic so_out,
   output logic so_oe,
   output logic req_valid,
   output logic [3:0] req_op,
   output logic [1:0] req_sel,
   output logic req_pot,
   output logic [pot_pkg::TAP_BITS-1:0] req_data
);
   import pot_pkg::*;

   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] sh;
      phase_t ph;
      logic [7:0] rdat;
      logic req;
      logic [3:0] op;
      logic [1:0] sel;
      logic pot;
      logic [TAP_BITS-1:0] data;
   } link_t;

   link_t r;
   link_t n;
   logic [2:0] pins_s;
   logic cs_low;
   logic [7:0] byte_in;
   logic [3:0] b_op;
   logic [1:0] b_sel;
   logic b_pot;
   logic id_ok;
   logic so_r;
   logic oe_r;

   assign cs_low = ~cs_n;

   // straps and the armed level, synchronised on the link clock
   cdc_sync #(.WIDTH(3), .RESET_VAL(LINK_SYNC_RESET)) u_pin_sync (
      .clk(sck),
      .rst_n(cs_low),
      .d({armed, address_select_pins}),
      .q(pins_s)
   );

   assign byte_in = {r.sh, si};
   assign b_op = byte_in[INSTR_OP_LSB +: 4];
   assign b_sel = byte_in[INSTR_SEL_LSB +: 2];
   assign b_pot = byte_in[INSTR_POT_BIT];
   assign id_ok = (byte_in[ID_TYPE_LSB +: 4] == DEVICE_TYPE)
      && (byte_in[ID_ZERO_LSB +: 2] == 2'h0)
      && (byte_in[ID_ADDR_LSB +: 2] == pins_s[1:0])
      && pins_s[2];

   always_comb begin
      n = r;
      // a paused bus freezes every bit of sequence state
      if (hold_n) begin
         n.cnt = r.cnt + 3'h1;
         n.sh = byte_in[6:0];
         if (r.cnt == 3'h7) begin
            case (r.ph)
               PH_ID: begin
                  n.ph = id_ok ? PH_INSTR : PH_IGNORE;
               end
               PH_INSTR: begin
                  n.op = b_op;
                  n.sel = b_sel;
                  n.pot = b_pot;
                  n.data = '0;
                  case (b_op)
                     OP_XFR_TO_WIPER, OP_XFR_TO_STORED: begin
                        n.req = 1'b1;
                        n.ph = PH_DONE;
                     end
                     OP_WRITE_WIPER, OP_WRITE_STORED: begin
                        n.ph = PH_WDATA;
                     end
                     OP_READ_WIPER: begin
                        n.rdat = {2'h0, wiper_img[b_pot]};
                        n.ph = PH_READ;
                     end
                     OP_READ_STORED: begin
                        n.rdat = {2'h0, stored_img[b_pot][b_sel]};
                        n.ph = PH_READ;
                     end
                     OP_READ_STATUS: begin
                        n.rdat = {7'h00, busy_img};
                        n.ph = PH_READ;
                     end
                     default: begin
                        n.ph = PH_DONE;
                     end
                  endcase
               end
               PH_WDATA: begin
                  n.data = byte_in[TAP_BITS-1:0];
                  n.req = 1'b1;
                  n.ph = PH_DONE;
               end
               PH_READ: begin
                  n.ph = PH_DONE;
               end
               default: begin
                  n.ph = r.ph;
               end
            endcase
         end
      end
   end

   // deselect is the transaction reset
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // read bits leave on the falling edge, most significant first
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         so_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         if (hold_n) begin
            so_r <= r.rdat[3'h7 - r.cnt];
         end
         oe_r <= (r.ph == PH_READ) && hold_n;
      end
   end

   assign so_out = so_r;
   assign so_oe = oe_r & ~cs_n;
   assign req_valid = r.req;
   assign req_op = r.op;
   assign req_sel = r.sel;
   assign req_pot = r.pot;
   assign req_data = r.data;
endmodule

module dual_pot_serial_host_port #(
   parameter int unsigned STORE_CYCLES = pot_pkg::STORE_CYCLES_DEF,
   parameter logic [pot_pkg::TAP_BITS-1:0] STORED_INIT = pot_pkg::STORED_RESET
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic [1:0] address_select_pins,
   input wire logic wp_n,
   output logic so_out,
   output logic so_oe,
   output logic [pot_pkg::TAP_BITS-1:0] wiper_position_0,
   output logic [pot_pkg::TAP_BITS-1:0] wiper_position_1,
   output logic [pot_pkg::TAPS-1:0] tap_select_0,
   output logic [pot_pkg::TAPS-1:0] tap_select_1,
   output logic store_busy_flag,
   output logic standby
);
   import pot_pkg::*;

   localparam int CNT_W = $clog2(STORE_CYCLES + 1);
   localparam int NPS = NUM_POTS * NUM_STORED;

   typedef struct packed {
      logic cs_prev;
      logic armed;
      logic boot;
      logic req_seen;
      logic [NUM_POTS-1:0][TAP_BITS-1:0] wiper;
      logic [NUM_POTS-1:0][NUM_STORED-1:0][TAP_BITS-1:0] stored;
      logic [NUM_POTS-1:0][TAP_BITS-1:0] wiper_img;
      logic [NUM_POTS-1:0][NUM_STORED-1:0][TAP_BITS-1:0] stored_img;
      logic busy_img;
      logic pend;
      logic pend_pot;
      logic [1:0] pend_sel;
      logic [TAP_BITS-1:0] pend_data;
      logic busy;
      logic [CNT_W-1:0] cnt;
      logic standby;
   } core_t;

   core_t r;
   core_t n;
   logic [1:0] rst_q;
   logic rst_sync_n;
   logic [2:0] sync_q;
   logic cs_h;
   logic wp_ok;
   logic req_s;
   logic req_valid;
   logic [3:0] req_op;
   logic [1:0] req_sel;
   logic req_pot;
   logic [TAP_BITS-1:0] req_data;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end

   assign rst_sync_n = rst_q[1];

   cdc_sync #(.WIDTH(3), .RESET_VAL(SYNC_RESET)) u_pin_sync (
      .clk(ref_clk),
      .rst_n(rst_sync_n),
      .d({cs_n, wp_n, req_valid}),
      .q(sync_q)
   );

   assign cs_h = sync_q[2];
   assign wp_ok = sync_q[1];
   assign req_s = sync_q[0];

   pot_serial_link u_link (
      .sck(sck),
      .cs_n(cs_n),
      .si(si),
      .hold_n(hold_n),
      .address_select_pins(address_select_pins),
      .armed(r.armed),
      .wiper_img(r.wiper_img),
      .stored_img(r.stored_img),
      .busy_img(r.busy_img),
      .so_out(so_out),
      .so_oe(so_oe),
      .req_valid(req_valid),
      .req_op(req_op),
      .req_sel(req_sel),
      .req_pot(req_pot),
      .req_data(req_data)
   );

   always_comb begin
      n = r;
      n.cs_prev = cs_h;
      if (r.cs_prev && !cs_h) begin
         n.armed = 1'b1;
      end
      if (r.boot) begin
         n.boot = 1'b0;
         for (int p = 0; p < NUM_POTS; p++) begin
            n.wiper[p] = r.stored[p][0];
         end
      end
      // request word is stable well before its valid level arrives here
      if (req_s && !cs_h && !r.req_seen) begin
         n.req_seen = 1'b1;
         case (req_op)
            OP_WRITE_WIPER: begin
               n.wiper[req_pot] = req_data;
            end
            OP_XFR_TO_WIPER: begin
               n.wiper[req_pot] = r.stored[req_pot][req_sel];
            end
            OP_WRITE_STORED: begin
               n.pend = 1'b1;
               n.pend_pot = req_pot;
               n.pend_sel = req_sel;
               n.pend_data = req_data;
            end
            OP_XFR_TO_STORED: begin
               n.pend = 1'b1;
               n.pend_pot = req_pot;
               n.pend_sel = req_sel;
               n.pend_data = r.wiper[req_pot];
            end
            default: begin
               n.req_seen = 1'b1;
            end
         endcase
      end
      if (cs_h) begin
         n.req_seen = 1'b0;
      end
      // store launches on deselect; protect or a running store refuses it
      if (!r.cs_prev && cs_h && r.pend) begin
         n.pend = 1'b0;
         if (wp_ok && !r.busy) begin
            n.busy = 1'b1;
            n.cnt = '0;
         end
      end
      if (r.busy) begin
         n.cnt = r.cnt + CNT_W'(1);
         if (r.cnt == CNT_W'(STORE_CYCLES - 1)) begin
            n.busy = 1'b0;
            n.stored[r.pend_pot][r.pend_sel] = r.pend_data;
         end
      end
      // images frozen while selected so the link reads stable words
      if (cs_h) begin
         n.wiper_img = r.wiper;
         n.stored_img = r.stored;
         n.busy_img = r.busy;
      end
      n.standby = cs_h && !r.busy;
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         r <= '0;
         r.cs_prev <= 1'b1;
         r.boot <= 1'b1;
         r.stored <= {NPS{STORED_INIT}};
         r.stored_img <= {NPS{STORED_INIT}};
      end else begin
         r <= n;
      end
   end

   tap_decoder #(.WIDTH(TAP_BITS), .TAPS(TAPS)) u_taps0 (
      .position(r.wiper[0]),
      .tap_on(tap_select_0)
   );

   tap_decoder #(.WIDTH(TAP_BITS), .TAPS(TAPS)) u_taps1 (
      .position(r.wiper[1]),
      .tap_on(tap_select_1)
   );

   assign wiper_position_0 = r.wiper[0];
   assign wiper_position_1 = r.wiper[1];
   assign store_busy_flag = r.busy;
   assign standby = r.standby;
endmodule

/* test/pot_port_asserts.sv */
// assertions on the pins of the dual potentiometer serial port
`timescale 1ns/1ps
module pot_port_asserts
   import pot_pkg::*;
#(
   parameter int unsigned STORE_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic [1:0] address_select_pins,
   input wire logic wp_n,
   input wire logic so_out,
   input wire logic so_oe,
   input wire logic [pot_pkg::TAP_BITS-1:0] wiper_position_0,
   input wire logic [pot_pkg::TAP_BITS-1:0] wiper_position_1,
   input wire logic [pot_pkg::TAPS-1:0] tap_select_0,
   input wire logic [pot_pkg::TAPS-1:0] tap_select_1,
   input wire logic store_busy_flag,
   input wire logic standby
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   int unsigned busy_cnt_r;
   logic [2:0] since_rst_r;
   // boot reload moves the wipers a few cycles after reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         since_rst_r <= 3'h0;
      end else if (since_rst_r != 3'h7) begin
         since_rst_r <= since_rst_r + 3'h1;
      end
   end
   // length of the running store
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_r <= 0;
      end else begin
         busy_cnt_r <= store_busy_flag ? busy_cnt_r + 1 : 0;
      end
   end
   cs_hiz_a: assert property (cs_n |-> !so_oe)
      else $error("so driven while deselected");
   active_mode_a: assert property (!cs_n [*5] |-> !standby)
      else $error("standby while selected");
   idle_standby_a: assert property ((cs_n && !store_busy_flag) [*8] |-> standby)
      else $error("no standby when idle");
   tap_zero_a: assert property (tap_select_0 == (TAPS'(1) << wiper_position_0))
      else $error("tap 0 decode wrong");
   tap_one_a: assert property (tap_select_1 == (TAPS'(1) << wiper_position_1))
      else $error("tap 1 decode wrong");
   store_len_a: assert property ($fell(store_busy_flag) |->
      busy_cnt_r + 1 >= STORE_CYCLES && busy_cnt_r <= STORE_CYCLES + 1)
      else $error("store length wrong");
   store_start_a: assert property ($rose(store_busy_flag) |-> cs_n)
      else $error("store began while selected");
   wp_block_a: assert property (!wp_n |-> !$rose(store_busy_flag))
      else $error("store ran while protected");
   wiper_src_a: assert property ($changed(wiper_position_0) ||
      $changed(wiper_position_1) |-> !cs_n || since_rst_r < 3'h6)
      else $error("wiper moved outside a frame");
   cover property ($rose(store_busy_flag));
   cover property ($rose(so_oe));
   cover property ($changed(wiper_position_1));
endmodule

bind dual_pot_serial_host_port pot_port_asserts #(.STORE_CYCLES(STORE_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
   .address_select_pins(address_select_pins), .wp_n(wp_n), .so_out(so_out),
   .so_oe(so_oe), .wiper_position_0(wiper_position_0),
   .wiper_position_1(wiper_position_1), .tap_select_0(tap_select_0),
   .tap_select_1(tap_select_1), .store_busy_flag(store_busy_flag), .standby(standby));

/* test/pot_host_model.sv */
// serial host model driving the potentiometer port
`timescale 1ns/1ps
module pot_host_model (
   output logic sck,
   output logic cs_n,
   output logic si,
   output logic hold_n,
   input wire logic so_out,
   input wire logic so_oe
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b1;
      hold_n = 1'b1;
   end
   // one frame, msb first; pause before bit hold_at; undriven so reads x
   task automatic frame(input logic [23:0] tx, input int n, input int hold_at,
      output logic [7:0] rx);
      int i;
      rx = '0;
      cs_n = 1'b0;
      #100;
      for (i = 0; i < n; i++) begin
         if (i == hold_at) begin
            hold_n = 1'b0;
            #50;
            // clock keeps running while paused; junk bits must be ignored
            repeat (3) begin
               si = ~si;
               #16 sck = 1'b1;
               #16 sck = 1'b0;
            end
            #50;
            hold_n = 1'b1;
            #50;
         end
         si = tx[23-i];
         #16 sck = 1'b1;
         if (i >= 16) rx[23-i] = so_oe ? so_out : 1'bx;
         #16 sck = 1'b0;
      end
      #250 cs_n = 1'b1;
      si = ~si;
      #250;
   endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the dual potentiometer serial port
`timescale 1ns/1ps
module testbench;
   import pot_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] pins = 2'b10; // single device on the bus
   logic wp_n = 1'b1;
   // non-zero stored setting so the power-up reload is visible
   localparam logic [5:0] BOOT_SET = 6'h0c;
   logic sck, cs_n, si, hold_n, so_out, so_oe, busy, standby;
   logic [TAP_BITS-1:0] w0, w1;
   logic [TAPS-1:0] t0, t1;
   logic [7:0] rx;
   int n_mismatch = 0;
   int tests_run = 0;
   always #10 ref_clk = ~ref_clk;
   dual_pot_serial_host_port #(.STORE_CYCLES(200), .STORED_INIT(BOOT_SET)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
      .address_select_pins(pins), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
      .wiper_position_0(w0), .wiper_position_1(w1), .tap_select_0(t0),
      .tap_select_1(t1), .store_busy_flag(busy), .standby(standby));
   pot_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
      .so_out(so_out), .so_oe(so_oe));
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] id(input logic [1:0] a);
      return {DEVICE_TYPE, 2'b00, a};
   endfunction
   function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] s, input logic p);
      return {op, s, 1'b0, p};
   endfunction
   task automatic run(input logic [7:0] i, input logic [7:0] d, input int n, input int h);
      host.frame({id(pins), i, d}, n, h, rx);
   endtask
   task automatic wait_store();
      int k;
      for (k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge ref_clk);
      check("busy end", busy, 1'b0);
   endtask
   task automatic t_reset();
      check("wiper0 init", w0, BOOT_SET);
      check("wiper1 init", w1, BOOT_SET);
      check("tap0 init", t0, 64'h1 << BOOT_SET);
      check("standby idle", standby, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_wiper();
      run(ins(OP_WRITE_WIPER, 2'h0, 1'b0), 8'hd5, 24, -1);
      check("wiper0 write", w0, 6'h15);
      check("tap0", t0, 64'h1 << 6'h15);
      run(ins(OP_WRITE_WIPER, 2'h0, 1'b1), 8'h2a, 24, 10);
      check("wiper1 paused", w1, 6'h2a);
      run(ins(OP_READ_WIPER, 2'h0, 1'b1), 8'h00, 24, -1);
      check("wiper1 read", rx, 8'h2a);
      check("wiper0 kept", w0, 6'h15);
      $display("test wiper done");
   endtask
   task automatic t_addr();
      logic [7:0] bad [3];
      int k;
      bad = '{id(2'b01), id(pins) ^ 8'h10, id(pins) | 8'h04};
      for (k = 0; k < 3; k++) begin
         host.frame({bad[k], ins(OP_WRITE_WIPER, 2'h0, 1'b0), 8'h3f}, 24, -1, rx);
         check("wiper0 bad id", w0, 6'h15);
         host.frame({bad[k], ins(OP_READ_WIPER, 2'h0, 1'b0), 8'h00}, 24, -1, rx);
         check("so bad id", rx, 8'hxx);
      end
      run({4'h7, 4'h0}, 8'h3f, 24, -1);
      check("wiper0 bad op", w0, 6'h15);
      @(negedge ref_clk) pins = 2'b01;
      run(ins(OP_WRITE_WIPER, 2'h0, 1'b0), 8'h07, 24, -1);
      check("wiper0 new pins", w0, 6'h07);
      $display("test address done");
   endtask
   task automatic t_store();
      run(ins(OP_WRITE_STORED, 2'h2, 1'b1), 8'h2d, 24, -1);
      check("busy", busy, 1'b1);
      check("standby store", standby, 1'b0);
      run(ins(OP_READ_STATUS, 2'h0, 1'b0), 8'h00, 24, -1);
      check("status", rx, 8'h01);
      wait_store();
      run(ins(OP_READ_STORED, 2'h2, 1'b1), 8'h00, 24, -1);
      check("stored read", rx, 8'h2d);
      run(ins(OP_XFR_TO_WIPER, 2'h2, 1'b1), 8'h00, 16, -1);
      check("xfr to wiper", w1, 6'h2d);
      check("tap1", t1, 64'h1 << 6'h2d);
      run(ins(OP_XFR_TO_STORED, 2'h1, 1'b0), 8'h00, 16, -1);
      wait_store();
      run(ins(OP_READ_STORED, 2'h1, 1'b0), 8'h00, 24, -1);
      check("xfr to stored", rx, 8'h07);
      @(negedge ref_clk) wp_n = 1'b0;
      run(ins(OP_WRITE_STORED, 2'h3, 1'b0), 8'h11, 24, -1);
      check("busy protected", busy, 1'b0);
      run(ins(OP_READ_STORED, 2'h3, 1'b0), 8'h00, 24, -1);
      check("stored protected", rx, {2'h0, BOOT_SET});
      @(negedge ref_clk) wp_n = 1'b1;
      $display("test store done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (20) @(negedge ref_clk);
      t_reset();
      t_wiper();
      t_addr();
      t_store();
      end_sim();
   end
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end
endmodule
